// *** logic/tecc_gen.sv ***
// code generator over bytes crossing the waveform or slave FIFO path
// assumes data path bytes on MCLK with a transfer qualifier; APB slave
//
// Function
// - one mode bit picks two 256-byte codes (0) or one 512-byte (1)
// - mode clear gives two 3-byte codes over consecutive 256-byte blocks
// - any write to restart register begins a new code from next bytes
// - dual mode stores first 256-byte code in first result register
// - dual mode stores next 256-byte code in second result register
// - dual mode freezes both results after second code until restart
// - mode set gives one 3-byte code over first 512 bytes
// - single mode uses only first result; second stays unused
// - single mode freezes first result after 512 bytes until restart
// - codes valid only with byte-wide interface; software sets that up
// - each code corrects one-bit and detects two-bit errors
`timescale 1ns/1ps
`include "tecc_defs.svh"
module tecc_gen
  import tecc_pkg::*;
#(
  parameter int CODE_BITS = `TECC_CODE_BITS
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // observed byte path
  input wire logic [7:0] XFER_DATA,
  input wire logic XFER_VALID,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // status
  output logic CODE_BUSY,
  output logic CODE_DONE
);
  // the code layout below is fixed at 24 bits; other widths are refused
  if (CODE_BITS != `TECC_CODE_BITS) begin : g_bad_width
    $error("tecc_gen: code width must be 24");
  end

  tecc_state_e state_r, state_nxt;
  logic code_block_size_select_r;
  logic byte_wide_r;
  logic [9:0] count_r, count_nxt;
  logic [23:0] first_code_result_r, second_code_result_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;

  // apb decode; two-cycle access phase (one wait) answered by registered pready
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction
  wire acc = PSEL && PENABLE && !pready_r;
  wire wr = acc && PWRITE;
  wire rd = acc && !PWRITE;
  wire hit_ctrl = hit(PADDR, `TECC_OFF_CTRL);
  wire hit_rst = hit(PADDR, `TECC_OFF_RESTART);
  wire hit_first = hit(PADDR, `TECC_OFF_FIRST);
  wire hit_second = hit(PADDR, `TECC_OFF_SECOND);
  wire hit_stat = hit(PADDR, `TECC_OFF_STATUS);
  wire mapped = hit_ctrl | hit_rst | hit_first | hit_second | hit_stat;
  wire code_restart_strobe = wr && hit_rst;

  // one 256-byte accumulator, cleared after the first half and on restart, and a 512-byte one run side by side
  wire take = XFER_VALID && byte_wide_r &&
              (state_r == TECC_FIRST || state_r == TECC_SECOND);
  wire [21:0] par_half;
  wire [23:0] par_full;
  wire clr_half = code_restart_strobe ||
                  (take && count_r == `TECC_BLK_BYTES - 10'h001);
  tecc_parity #(.IDX_BITS(8)) u_half (
    .clk(MCLK), .clr(SYS_RST || clr_half), .en(take),
    .idx(count_r[7:0]), .data(XFER_DATA), .par(par_half)
  );
  tecc_parity #(.IDX_BITS(9)) u_full (
    .clk(MCLK), .clr(SYS_RST || code_restart_strobe), .en(take),
    .idx(count_r[8:0]), .data(XFER_DATA), .par(par_full)
  );
  // next parity including the byte taken this cycle
  wire [5:0] col_in = {^(XFER_DATA & 8'hF0), ^(XFER_DATA & 8'h0F),
                       ^(XFER_DATA & 8'hCC), ^(XFER_DATA & 8'h33),
                       ^(XFER_DATA & 8'hAA), ^(XFER_DATA & 8'h55)};
  wire bp = ^XFER_DATA;
  function automatic logic [17:0] lines(input logic [8:0] i,
                                        input logic p);
    logic [17:0] l;
    l = '0;
    for (int k = 0; k < 9; k++) begin
      l[2*k+1] = p & i[k];
      l[2*k] = p & ~i[k];
    end
    return l;
  endfunction
  wire [17:0] ln = lines(count_r[8:0], bp);
  // code stored inverted, as line/column parity codes customarily are
  wire [23:0] half_code = ~({2'b00, par_half} ^
                            {2'b00, ln[15:0], col_in});
  wire [23:0] full_code = ~(par_full ^ {ln, col_in});
  wire last_half = take && count_r[7:0] == 8'(`TECC_BLK_BYTES - 10'h001);
  wire last_full = take && count_r == `TECC_BIG_BYTES - 10'h001;

  always_comb begin
    state_nxt = state_r;
    count_nxt = take ? count_r + 10'h001 : count_r;
    if (code_restart_strobe) begin
      state_nxt = TECC_FIRST;
      count_nxt = '0;
    end else begin
      unique case (state_r)
        TECC_IDLE: state_nxt = TECC_IDLE;
        TECC_FIRST: begin
          if (!code_block_size_select_r && last_half) begin
            state_nxt = TECC_SECOND;
          end else if (code_block_size_select_r && last_full) begin
            state_nxt = TECC_FROZEN;
          end
        end
        TECC_SECOND: begin
          if (last_half) begin
            state_nxt = TECC_FROZEN;
          end
        end
        TECC_FROZEN: state_nxt = TECC_FROZEN;
      endcase
    end
  end

  wire st_first = state_r == TECC_FIRST;
  wire dual = !code_block_size_select_r;
  wire ld_first = st_first && (dual ? last_half : last_full);
  wire ld_second = state_r == TECC_SECOND && dual && last_half;

  // status and control words built from their field positions
  wire stat_busy = state_r == TECC_FIRST || state_r == TECC_SECOND;
  wire stat_done1 = state_r == TECC_FROZEN || state_r == TECC_SECOND;
  wire stat_done2 = state_r == TECC_FROZEN && dual;
  wire [31:0] stat_word = (32'(stat_busy) << `TECC_ST_BUSY) |
                          (32'(stat_done1) << `TECC_ST_DONE1) |
                          (32'(stat_done2) << `TECC_ST_DONE2);
  wire [31:0] ctrl_word =
    (32'(code_block_size_select_r) << `TECC_CTRL_MODE) |
    (32'(byte_wide_r) << `TECC_CTRL_WIDE);
  wire [31:0] rd_mux =
    hit_ctrl ? ctrl_word :
    hit_first ? {8'h00, first_code_result_r} :
    hit_second ? {8'h00, second_code_result_r} :
    hit_stat ? stat_word :
    32'h0;

  // sequencing: state and count of taken bytes
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_r <= TECC_IDLE;
      count_r <= '0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  // bus answer one cycle after the access edge; data zero outside it
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= acc;
      pslverr_r <= acc && !mapped;
      prdata_r <= rd ? rd_mux : 32'h0;
    end
  end

  // control bits; a mode change inside a block is not defined
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      code_block_size_select_r <= 1'b0;
      byte_wide_r <= 1'b1;
    end else if (wr && hit_ctrl) begin
      code_block_size_select_r <= PWDATA[`TECC_CTRL_MODE];
      byte_wide_r <= PWDATA[`TECC_CTRL_WIDE];
    end
  end

  // results: restart clears, then first loads once per calculation, second once in dual mode only
  always_ff @(posedge MCLK) begin
    if (SYS_RST || code_restart_strobe) begin
      first_code_result_r <= '0;
      second_code_result_r <= '0;
    end else begin
      if (ld_first) begin
        first_code_result_r <= dual ? half_code : full_code;
      end
      if (ld_second) begin
        second_code_result_r <= half_code;
      end
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      CODE_BUSY <= 1'b0;
      CODE_DONE <= 1'b0;
    end else begin
      CODE_BUSY <= state_nxt == TECC_FIRST || state_nxt == TECC_SECOND;
      CODE_DONE <= state_nxt == TECC_FROZEN;
    end
  end
endmodule

// *** shared/tecc_defs.svh ***
// constants for the transfer code generator
// assumes inclusion by both the package user and the design modules
`ifndef TECC_DEFS_SVH
`define TECC_DEFS_SVH
`define TECC_OFF_CTRL 12'h000
`define TECC_OFF_RESTART 12'h004
`define TECC_OFF_FIRST 12'h008
`define TECC_OFF_SECOND 12'h00C
`define TECC_OFF_STATUS 12'h010
`define TECC_BLK_BYTES 10'h100
`define TECC_BIG_BYTES 10'h200
`define TECC_CODE_BITS 24
`define TECC_CTRL_MODE 0
`define TECC_CTRL_WIDE 1
`define TECC_ST_DONE1 0
`define TECC_ST_DONE2 1
`define TECC_ST_BUSY 2
`endif

// *** shared/tecc_pkg.sv ***
// types of the transfer code generator
// assumes tecc_defs.svh is visible to its users
package tecc_pkg;
  typedef enum logic [1:0] {
    TECC_IDLE, TECC_FIRST, TECC_SECOND, TECC_FROZEN
  } tecc_state_e;
endpackage

// *** logic/tecc_parity.sv ***
// running line and column parity over one block of bytes
// assumes one byte per cycle with a valid qualifier, same clock
`timescale 1ns/1ps
`include "tecc_defs.svh"
module tecc_parity #(
  parameter int IDX_BITS = 9
) (
  input wire logic clk,
  input wire logic clr,
  input wire logic en,
  input wire logic [IDX_BITS-1:0] idx,
  input wire logic [7:0] data,
  output logic [2*IDX_BITS+5:0] par
);
  // par: {line parities, 2 per index bit; column parities 6 bits}
  localparam int W = 2 * IDX_BITS + 6;
  logic [W-1:0] par_r;
  logic [W-1:0] par_nxt;
  wire byte_par = ^data;
  wire [5:0] col = {^(data & 8'hF0), ^(data & 8'h0F),
                    ^(data & 8'hCC), ^(data & 8'h33),
                    ^(data & 8'hAA), ^(data & 8'h55)};
  logic [2*IDX_BITS-1:0] line;
  genvar g;
  generate
    for (g = 0; g < IDX_BITS; g++) begin : g_line
      assign line[2*g+1] = byte_par & idx[g];
      assign line[2*g] = byte_par & ~idx[g];
    end
  endgenerate
  assign par_nxt = par_r ^ {line, col};
  always_ff @(posedge clk) begin
    if (clr) begin
      par_r <= '0;
    end else if (en) begin
      par_r <= par_nxt;
    end
  end
  assign par = par_r;
endmodule

// *** tb/tecc_gen_sva.sv ***
// port checker for the transfer code generator
// assumes a bind onto tecc_gen, single clock domain
`timescale 1ns/1ps
`include "tecc_defs.svh"
module tecc_gen_chk (
  input wire logic MCLK, SYS_RST, PSEL, PENABLE, PWRITE, XFER_VALID,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY, PSLVERR, CODE_BUSY, CODE_DONE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  logic [9:0] cnt_r;
  wire acc = PSEL && PENABLE && !PREADY;
  wire rst_wr = acc && PWRITE && PADDR == `TECC_OFF_RESTART;
  wire mapped = PADDR inside {`TECC_OFF_CTRL, `TECC_OFF_RESTART,
    `TECC_OFF_FIRST, `TECC_OFF_SECOND, `TECC_OFF_STATUS};
  sequence restart_s; rst_wr; endsequence
  sequence accum_s; CODE_BUSY && !CODE_DONE; endsequence
  // both modes freeze after 512 taken bytes in total
  always_ff @(posedge MCLK)
    if (SYS_RST || rst_wr) cnt_r <= '0;
    else if (XFER_VALID && CODE_BUSY) cnt_r <= cnt_r + 10'h001;
  chk_ready_wait: assert property (acc |=> PREADY)
    else $error("no answer after one wait");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  chk_err_map: assert property (PREADY |-> PSLVERR == !mapped)
    else $error("error flag wrong for address");
  chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");
  chk_restart_busy: assert property (restart_s |=> accum_s)
    else $error("restart did not start accumulation");
  chk_state_excl: assert property (!(CODE_BUSY && CODE_DONE))
    else $error("busy and done together");
  chk_done_hold: assert property
    (CODE_DONE && !rst_wr |=> CODE_DONE)
    else $error("frozen codes released without restart");
  chk_done_count: assert property
    ($rose(CODE_DONE) |-> cnt_r == `TECC_BIG_BYTES)
    else $error("done after wrong byte count");
endmodule
bind tecc_gen tecc_gen_chk u_chk (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .XFER_VALID(XFER_VALID), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CODE_BUSY(CODE_BUSY), .CODE_DONE(CODE_DONE)
);

// *** tb/tecc_src.sv ***
// byte source standing in for the waveform or slave FIFO side
// assumes send is called from the bench thread
`timescale 1ns/1ps
module tecc_src (
  input wire logic clk,
  output logic [7:0] dat,
  output logic vld
);
  logic [7:0] mem [512];
  initial begin
    dat = 8'h00;
    vld = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // idle data flips so a stale byte never matches by luck
  task automatic send(input int n, input bit st);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (st && $urandom_range(1)) begin
        vld <= 1'b0;
        dat <= ~dat;
        i--;
      end else begin
        vld <= 1'b1;
        dat <= i < 512 ? mem[i] : 8'($urandom);
      end
    end
    @(posedge clk);
    vld <= 1'b0;
    dat <= ~dat;
  endtask
endmodule

// *** tb/tecc_gen_tb_top.sv ***
// self-checking bench for the transfer code generator
// assumes tecc_src as byte source and the bound checker
`timescale 1ns/1ps
`include "tecc_defs.svh"
module tecc_gen_tb_top;
  logic MCLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, e;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, a1, a2, b1, b2, t;
  logic [7:0] XFER_DATA;
  logic XFER_VALID, PREADY, PSLVERR, CODE_BUSY, CODE_DONE;
  int error_cnt = 0, checks = 0;
  always #2 MCLK = ~MCLK;
  tecc_gen u_tecc_gen (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .XFER_DATA(XFER_DATA),
    .XFER_VALID(XFER_VALID), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CODE_BUSY(CODE_BUSY),
    .CODE_DONE(CODE_DONE)
  );
  tecc_src u_tecc_src (.clk(MCLK), .dat(XFER_DATA), .vld(XFER_VALID));
  // all-zero data leaves every parity clear, inverted to ones
  function automatic logic [31:0] zcode();
    return (32'h1 << `TECC_CODE_BITS) - 32'h1;
  endfunction
  // reference: column parity by bit position, line parity by byte index
  function automatic logic [23:0] ecode(input int base, input int n);
    logic [23:0] p;
    int nb;
    p = '0;
    nb = (n == `TECC_BIG_BYTES) ? 9 : 8;
    for (int i = 0; i < n; i++) begin
      for (int b = 0; b < 8; b++) begin
        if (u_tecc_src.mem[base + i][b]) begin
          for (int k = 0; k < 3; k++) p[2*k + b[k]] ^= 1'b1;
          for (int k = 0; k < nb; k++) p[6 + 2*k + i[k]] ^= 1'b1;
        end
      end
    end
    return ~p;
  endfunction
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, x);
    checks++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge MCLK);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    if (PREADY !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, logic xe);
    apb(1'b0, a, 32'h0, t);
    chk(t, x);
    chk(e, xe);
  endtask
  task automatic go(input logic [31:0] c, input int n, input bit st);
    apb(1'b1, `TECC_OFF_CTRL, c, t);
    apb(1'b1, `TECC_OFF_RESTART, $urandom, t);
    u_tecc_src.send(n, st);
  endtask
  task automatic rd2(output logic [31:0] x, y);
    apb(1'b0, `TECC_OFF_FIRST, 32'h0, x);
    apb(1'b0, `TECC_OFF_SECOND, 32'h0, y);
  endtask
  initial begin
    void'($urandom(91331));
    repeat (10) @(posedge MCLK);
    SYS_RST <= 1'b0;
    u_tecc_src.send(300, 1);
    rd(`TECC_OFF_FIRST, 0, 0);
    rd(`TECC_OFF_STATUS, 0, 0);
    rd(12'h014, 0, 1);
    go(3, 256, 0);
    rd(`TECC_OFF_STATUS, 4, 0);
    u_tecc_src.send(356, 0);
    rd(`TECC_OFF_FIRST, zcode(), 0);
    rd(`TECC_OFF_SECOND, 0, 0);
    go(2, 612, 0);
    rd(`TECC_OFF_FIRST, zcode(), 0);
    rd(`TECC_OFF_SECOND, zcode(), 0);
    rd(`TECC_OFF_STATUS, 3, 0);
    go(0, 300, 0);
    rd(`TECC_OFF_STATUS, 4, 0);
    rd(`TECC_OFF_FIRST, 0, 0);
    foreach (u_tecc_src.mem[i]) u_tecc_src.mem[i] = 8'($urandom);
    go(2, 512, 0);
    rd2(a1, a2);
    chk(a1, ecode(0, `TECC_BLK_BYTES));
    chk(a2, ecode(`TECC_BLK_BYTES, `TECC_BLK_BYTES));
    go(2, 512, 1);
    rd2(b1, b2);
    chk(b1, a1);
    chk(b2, a2);
    u_tecc_src.mem[7] ^= 8'h10;
    go(2, 512, 0);
    rd2(b1, b2);
    chk(b1 != a1, 1);
    chk(b1, ecode(0, `TECC_BLK_BYTES));
    chk(b2, a2);
    u_tecc_src.mem[7] ^= 8'h10;
    u_tecc_src.mem[300] ^= 8'h21;
    go(2, 512, 0);
    rd2(b1, b2);
    chk(b1, a1);
    chk(b2 != a2, 1);
    go(3, 600, 0);
    rd(`TECC_OFF_FIRST, ecode(0, `TECC_BIG_BYTES), 0);
    rd(`TECC_OFF_SECOND, 0, 0);
    rd(`TECC_OFF_STATUS, 1, 0);
    end_of_test();
  end
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
endmodule
